/* File: design/pies_top.sv */
// PWM interrupt event select with AXI4-Lite register access
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/100ps
module pies_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // PWM counter and channel outputs
  input wire pies_pkg::pies_pwm_t pwm_in,
  // Interrupt outputs
  output logic pwm_event_req,
  output logic irq
);

  // Register state
  logic [7:0] select_q;
  logic status_q;
  logic enable_q;
  logic event_q;
  logic irq_q;

  // Bus state
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic aw_held_q;
  logic w_held_q;
  logic [11:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  // Maps a raw channel code onto a legal channel index
  function automatic logic [2:0] chan_index(input logic [2:0] code);
    chan_index = (code > pies_pkg::CHAN_CODE_MAX) ? 3'h0 : code;
  endfunction

  // Edge detection
  logic [pies_pkg::NUM_CHAN-1:0] ch_rise;
  logic [pies_pkg::NUM_CHAN-1:0] ch_fall;

  pies_edge #(
    .WIDTH(pies_pkg::NUM_CHAN)
  ) u_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .level(pwm_in.waveform_channel),
    .rise(ch_rise),
    .fall(ch_fall)
  );

  // Event selection
  wire pies_pkg::pies_evt_type_t event_type_select =
    pies_pkg::pies_evt_type_t'(select_q[pies_pkg::TYPE_SEL_LSB +: 2]);
  wire [2:0] edge_channel_select = select_q[pies_pkg::CHAN_SEL_LSB +: 3];
  wire [2:0] chan_idx = chan_index(edge_channel_select);
  wire sel_rise = ch_rise[chan_idx];
  wire sel_fall = ch_fall[chan_idx];
  logic event_hit;

  always_comb begin
    unique case (event_type_select)
      pies_pkg::EVT_FALL_EDGE: begin
        event_hit = sel_fall;
      end
      pies_pkg::EVT_RISE_EDGE: begin
        event_hit = sel_rise;
      end
      // Channel field is ignored for the period points
      pies_pkg::EVT_PERIOD_CENTRE: begin
        event_hit = pwm_in.center_aligned & pwm_in.period_centre;
      end
      pies_pkg::EVT_PERIOD_END: begin
        event_hit = pwm_in.center_aligned & pwm_in.period_end;
      end
    endcase
  end

  // Write decode
  wire wr_fire = aw_held_q & w_held_q & ~bvalid_q;
  wire wr_sel = wr_fire & (waddr_q == pies_pkg::ADDR_INT_SELECT);
  wire wr_clr = wr_fire & (waddr_q == pies_pkg::ADDR_INT_CLEAR);
  wire wr_en = wr_fire & (waddr_q == pies_pkg::ADDR_INT_ENABLE);
  wire wr_stat = wr_fire & (waddr_q == pies_pkg::ADDR_INT_STATUS);
  wire wr_known = wr_sel | wr_clr | wr_en | wr_stat;
  wire lane0 = wstrb_q[0];
  wire clr_bit = wr_clr & lane0 & wdata_q[0];

  // Set wins over a clear in the same cycle
  wire status_d = (status_q & ~clr_bit) | event_hit;
  wire irq_d = status_d & enable_q;

  // Read decode
  wire ar_take = s_axi_arvalid & arready_q;
  wire rd_sel = s_axi_araddr == pies_pkg::ADDR_INT_SELECT;
  wire rd_stat = s_axi_araddr == pies_pkg::ADDR_INT_STATUS;
  wire rd_clr = s_axi_araddr == pies_pkg::ADDR_INT_CLEAR;
  wire rd_en = s_axi_araddr == pies_pkg::ADDR_INT_ENABLE;
  wire rd_known = rd_sel | rd_stat | rd_clr | rd_en;
  wire [31:0] rd_data =
    rd_sel ? {24'h000000, select_q} :
    rd_stat ? {31'h0, status_q} :
    rd_en ? {31'h0, enable_q} : 32'h00000000;

  // Register file and interrupt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      select_q <= pies_pkg::SELECT_RESET;
      enable_q <= pies_pkg::ENABLE_RESET;
      status_q <= pies_pkg::STATUS_RESET;
      event_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      if (wr_sel && lane0) begin
        select_q <= wdata_q[7:0] & pies_pkg::SELECT_WR_MASK;
      end
      if (wr_en && lane0) begin
        enable_q <= wdata_q[0];
      end
      status_q <= status_d;
      event_q <= event_hit;
      irq_q <= irq_d;
    end
  end

  // Write channels: address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      waddr_q <= 12'h000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= pies_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        waddr_q <= s_axi_awaddr;
        aw_held_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_held_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_known ? pies_pkg::RESP_OKAY : pies_pkg::RESP_SLVERR;
      end
      // Readiness returns only after the response, so one write at a time
      if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // Read channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= pies_pkg::RESP_OKAY;
    end else begin
      if (ar_take) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rd_data;
        rresp_q <= rd_known ? pies_pkg::RESP_OKAY : pies_pkg::RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign pwm_event_req = event_q;
  assign irq = irq_q;

endmodule

/* File: design/pies_pkg.sv */
// Constants and types shared by the PWM interrupt event select block
package pies_pkg;

  localparam int unsigned NUM_CHAN = 6;

  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_INT_SELECT = 8'hB7;
  localparam logic [7:0] IDX_INT_STATUS = 8'hC0;
  localparam logic [7:0] IDX_INT_CLEAR = 8'hC1;
  localparam logic [7:0] IDX_INT_ENABLE = 8'hC2;

  localparam logic [11:0] ADDR_INT_SELECT = {2'h0, IDX_INT_SELECT, 2'h0};
  localparam logic [11:0] ADDR_INT_STATUS = {2'h0, IDX_INT_STATUS, 2'h0};
  localparam logic [11:0] ADDR_INT_CLEAR = {2'h0, IDX_INT_CLEAR, 2'h0};
  localparam logic [11:0] ADDR_INT_ENABLE = {2'h0, IDX_INT_ENABLE, 2'h0};

  // Field positions inside pwm_interrupt_select
  localparam int unsigned CHAN_SEL_LSB = 0;
  localparam int unsigned TYPE_SEL_LSB = 4;
  localparam logic [7:0] SELECT_WR_MASK = 8'h37;

  // Values after reset
  localparam logic [7:0] SELECT_RESET = 8'h00;
  localparam logic STATUS_RESET = 1'h0;
  localparam logic ENABLE_RESET = 1'h0;

  // Highest legal channel code
  localparam logic [2:0] CHAN_CODE_MAX = 3'h5;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    EVT_FALL_EDGE,
    EVT_RISE_EDGE,
    EVT_PERIOD_CENTRE,
    EVT_PERIOD_END
  } pies_evt_type_t;

  // Signals coming from the PWM counter and output logic
  typedef struct packed {
    logic [NUM_CHAN-1:0] waveform_channel;
    logic center_aligned;
    logic period_centre;
    logic period_end;
  } pies_pwm_t;

endpackage

/* File: design/pies_edge.sv */
// Per-channel edge detector against the previous clock's value
`timescale 1ns/100ps
module pies_edge #(
  parameter int unsigned WIDTH = 6
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Channel levels in, edge flags out
  input wire logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] prev_q;

  for (genvar i = 0; i < WIDTH; i++) begin : g_chan
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        prev_q[i] <= 1'b0;
      end else begin
        prev_q[i] <= level[i];
      end
    end
    assign rise[i] = level[i] & ~prev_q[i];
    assign fall[i] = ~level[i] & prev_q[i];
  end

endmodule

/* File: testbench/pies_sva.sv */
// Assertion checker for the PWM interrupt event select block
`timescale 1ns/100ps
module pies_sva (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register writes
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Event side
  input wire pies_pkg::pies_pwm_t pwm_in,
  input wire logic pwm_event_req
);
  logic [11:0] wa_q;
  logic [7:0] wd_q;
  logic [7:0] sel_q;
  logic [5:0] pw_q;
  logic ok_q;
  wire [2:0] ch = (sel_q[2:0] > 3'h5) ? 3'h0 : sel_q[2:0];
  wire [1:0] ty = sel_q[5:4];
  wire ca = pwm_in.center_aligned;
  wire pc = pwm_in.period_centre;
  wire pe = pwm_in.period_end;
  wire lv = pwm_in.waveform_channel[ch];
  wire pl = pw_q[ch];
  // Skip the cycles around every write response, where the select mirror may lag the design
  wire quiet = ok_q && !s_axi_bvalid;
  wire hit = ty[1] ? ca && (ty[0] ? pe : pc) :
             (ty[0] ? !pl && lv : pl && !lv);
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) wa_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata[7:0];
    pw_q <= aresetn ? pwm_in.waveform_channel : 6'h00;
    ok_q <= aresetn && !s_axi_bvalid;
    if (!aresetn) sel_q <= 8'h00;
    else if (s_axi_bvalid && s_axi_bready && wa_q == pies_pkg::ADDR_INT_SELECT) sel_q <= wd_q;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_fall_req: assert property (quiet && ty == 2'h0 && pl && !lv |=> pwm_event_req)
    else $error("falling edge gave no request");
  a_rise_req: assert property (quiet && ty == 2'h1 && !pl && lv |=> pwm_event_req)
    else $error("rising edge gave no request");
  a_centre_req: assert property (quiet && ty == 2'h2 && ca && pc |=> pwm_event_req)
    else $error("period centre gave no request");
  a_end_req: assert property (quiet && ty == 2'h3 && ca && pe |=> pwm_event_req)
    else $error("period end gave no request");
  a_edge_mode: assert property (quiet && ty[1] && !ca |=> !pwm_event_req)
    else $error("period event outside centre mode");
  a_no_cause: assert property (quiet && !hit |=> !pwm_event_req)
    else $error("request without selected event");
endmodule
bind pies_top pies_sva u_sva (.*);

/* File: testbench/pies_pwm_model.sv */
// Behavioural PWM counter and channel outputs feeding the selector
`timescale 1ns/100ps
module pies_pwm_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bench control; step low stalls the counter
  input wire logic center_mode,
  input wire logic step,
  // Counter outputs
  output pies_pkg::pies_pwm_t pwm
);
  logic [3:0] cnt_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) cnt_q <= 4'h0;
    else if (step) cnt_q <= cnt_q + 4'h1;
  end
  // Markers pulse in both modes, as the real counter may; gating is the selector's job
  always_comb begin
    for (int i = 0; i < 6; i++) pwm.waveform_channel[i] = cnt_q < 4'(2 * i + 2);
    pwm.center_aligned = center_mode;
    pwm.period_centre = step && cnt_q == 4'h7;
    pwm.period_end = step && cnt_q == 4'hF;
  end
endmodule

/* File: testbench/pies_top_tb.sv */
// Self-checking bench for the PWM interrupt event select block
`timescale 1ns/100ps
module pies_top_tb;
  logic aclk, aresetn, ca_mode, step, mon, pwm_event_req, irq;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv, r;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
  logic [7:0] sel_m;
  logic [5:0] pw;
  pies_pkg::pies_pwm_t pwm_in;
  int err_count, n_tests, e, ch, q[$];
  pies_top dut (.*);
  pies_pwm_model pm (.aclk, .aresetn, .center_mode(ca_mode), .step, .pwm(pwm_in));
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %0h want %0h", $time, got, exp);
    end
  endtask
  task automatic chk_evt(input logic got, input int exp);
    n_tests++;
    if (got !== exp[0]) begin
      err_count++;
      $display("BAD %0t request %0b want %0b", $time, got, exp[0]);
    end
  endtask
  task automatic chk_irq(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t interrupt %0b want %0b", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t response %0h want %0h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Reference model: the request is due one cycle after the event it reports
  always @(negedge aclk) begin
    if (mon && q.size() > 0) chk_evt(pwm_event_req, q.pop_front());
    ch = (sel_m[2:0] > 3'h5) ? 0 : sel_m[2:0];
    case (sel_m[5:4])
      2'h0: e = pw[ch] & !pwm_in.waveform_channel[ch];
      2'h1: e = !pw[ch] & pwm_in.waveform_channel[ch];
      2'h2: e = pwm_in.center_aligned & pwm_in.period_centre;
      default: e = pwm_in.center_aligned & pwm_in.period_end;
    endcase
    if (mon) q.push_back(e);
    else q.delete();
    pw = pwm_in.waveform_channel;
  end
  initial begin
    #500000;
    err_count++;
    complete_run();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, ca_mode, step, mon, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    sel_m = 8'h00;
    void'($urandom(32'h5EE1A8D3));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(pies_pkg::ADDR_INT_SELECT);
    chk(rv, {24'h0, pies_pkg::SELECT_RESET});
    rd(12'h000);
    chk_resp(rr, pies_pkg::RESP_SLVERR);
    chk(rv, 32'h0);
    // An unmapped write must be refused and leave the select byte alone
    wr(12'h000, 32'hFFFFFFFF);
    chk_resp(br, pies_pkg::RESP_SLVERR);
    rd(pies_pkg::ADDR_INT_SELECT);
    chk(rv, {24'h0, pies_pkg::SELECT_RESET});
    for (int m = 0; m < 64; m++) begin
      ca_mode <= m[5];
      r = $urandom;
      wr(pies_pkg::ADDR_INT_SELECT, {r[31:6], m[4:3], r[3], m[2:0]});
      chk_resp(br, pies_pkg::RESP_OKAY);
      rd(pies_pkg::ADDR_INT_SELECT);
      chk(rv, {26'h0, m[4:3], 1'h0, m[2:0]});
      sel_m = {2'h0, m[4:3], 1'h0, m[2:0]};
      mon = 1'b1;
      repeat (40) begin
        @(posedge aclk);
        step <= ($urandom % 4) != 0;
      end
      mon = 1'b0;
    end
    // Status is set by now, but the interrupt stays masked until enabled
    @(posedge aclk);
    chk_irq(irq, 1'b0);
    rd(pies_pkg::ADDR_INT_STATUS);
    chk(rv, 32'h1);
    ca_mode <= 1'b1;
    step <= 1'b1;
    wr(pies_pkg::ADDR_INT_ENABLE, 32'h1);
    chk_resp(br, pies_pkg::RESP_OKAY);
    rd(pies_pkg::ADDR_INT_ENABLE);
    chk(rv, 32'h1);
    repeat (20) @(posedge aclk);
    ca_mode <= 1'b0;
    repeat (3) @(posedge aclk);
    chk_irq(irq, 1'b1);
    rd(pies_pkg::ADDR_INT_STATUS);
    chk(rv, 32'h1);
    wr(pies_pkg::ADDR_INT_ENABLE, 32'h0);
    repeat (2) @(posedge aclk);
    chk_irq(irq, 1'b0);
    wr(pies_pkg::ADDR_INT_CLEAR, 32'h1);
    chk_resp(br, pies_pkg::RESP_OKAY);
    rd(pies_pkg::ADDR_INT_CLEAR);
    chk(rv, 32'h0);
    rd(pies_pkg::ADDR_INT_STATUS);
    chk(rv, 32'h0);
    complete_run();
  end
endmodule
